// >>> include/drc_pkg.sv
// package: register map, field positions and codes for dram refresh control
package drc_pkg;
   localparam logic [11:0] MTC_OFFSET = 12'h000;
   localparam logic [11:0] RFC_OFFSET = 12'h004;
   localparam logic [11:0] CNT_OFFSET = 12'h008;
   localparam logic [11:0] CMP_OFFSET = 12'h00c;
   localparam logic [11:0] STS_OFFSET = 12'h010;
   localparam logic [7:0] MTC_RESET = 8'h00;
   localparam logic [7:0] RFC_RESET = 8'h00;
   localparam logic [7:0] CNT_RESET = 8'h00;
   localparam logic [7:0] CMP_RESET = 8'hff;
   localparam int MTC_PRECHARGE_BIT = 7;
   localparam int MTC_BURST_BIT = 6;
   localparam int MTC_ROW_HOLD_BIT = 5;
   localparam int MTC_DUAL_CAS_BIT = 4;
   localparam int MTC_MUX_SHIFT_LSB = 2;
   localparam int MTC_REFRESH_WAIT_LSB = 0;
   localparam int RFC_ENABLE_BIT = 7;
   localparam int RFC_STROBE_WAIT_BIT = 6;
   localparam int RFC_MODE_BIT = 5;
   localparam int RFC_FLAG_BIT = 4;
   localparam int RFC_IRQ_EN_BIT = 3;
   localparam int RFC_CLK_SEL_LSB = 0;
   localparam int ROW_BASE_SHIFT = 8;
   localparam int ROW_TOP_BIT = 23;
   localparam logic [11:0] PRESCALE_TOP = 12'hfff;
   typedef enum logic [1:0] {
      DRC_SHIFT_8,
      DRC_SHIFT_9,
      DRC_SHIFT_10,
      DRC_SHIFT_UNDEF
   } drc_shift_e;
endpackage

// >>> core/drc_prescaler.sv
// free-running system clock divider with selectable tap enable pulse
`timescale 1ns/1ps
module drc_prescaler #(
   parameter int WIDTH = 12
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [2:0] i_sel,
   output logic o_tick
);
   import drc_pkg::*;
   typedef struct packed {
      logic [WIDTH-1:0] div;
      logic tick;
   } drc_pre_s;
   drc_pre_s st_q;
   drc_pre_s st_d;
   logic [WIDTH-1:0] mask;

   // dividers /2 /8 /32 /128 /512 /2048 /4096
   always_comb begin
      case (i_sel)
         3'h1: mask = WIDTH'(12'h001);
         3'h2: mask = WIDTH'(12'h007);
         3'h3: mask = WIDTH'(12'h01f);
         3'h4: mask = WIDTH'(12'h07f);
         3'h5: mask = WIDTH'(12'h1ff);
         3'h6: mask = WIDTH'(12'h7ff);
         3'h7: mask = WIDTH'(PRESCALE_TOP);
         default: mask = '0;
      endcase
   end

   always_comb begin
      st_d = st_q;
      st_d.div = st_q.div + 1'b1;
      // code 000 suppresses the tick, the divider itself keeps counting
      st_d.tick = (i_sel != 3'h0) && ((st_q.div & mask) == mask);
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign o_tick = st_q.tick;

   a_tick_off: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (i_sel == 3'h0) |=> !o_tick)
      else $error("tick with clock off");
   a_div2_tick: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (i_sel == 3'h1)[*3] |-> (o_tick != $past(o_tick)))
      else $error("div2 not alternating");
endmodule

// >>> core/drc_row_compare.sv
// row address mux shift and burst row-hit compare
`timescale 1ns/1ps
module drc_row_compare (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [23:0] i_addr,
   input wire logic [23:0] i_last_addr,
   input wire logic [1:0] i_shift,
   input wire logic i_byte_space,
   output logic [23:0] o_row,
   output logic o_row_hit
);
   import drc_pkg::*;
   typedef struct packed {
      logic [23:0] row;
      logic hit;
   } drc_row_s;
   drc_row_s st_q;
   drc_row_s st_d;
   logic [4:0] sh;
   logic [4:0] lsb;
   logic [23:0] cmask;

   always_comb begin
      st_d = st_q;
      sh = 5'(ROW_BASE_SHIFT) + {3'h0, i_shift};
      lsb = sh + {4'h0, !i_byte_space};
      cmask = 24'hffffff << lsb;
      st_d.row = i_addr >> sh;
      st_d.hit = ((i_addr ^ i_last_addr) & cmask) == 24'h0;
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign o_row = st_q.row;
   assign o_row_hit = st_q.hit;

   a_row_shift: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (i_shift == 2'h0) |=> (o_row == ($past(i_addr) >> 8)))
      else $error("row shift wrong");
endmodule

// >>> core/drc_top.sv
// dram interface configuration, refresh timer and refresh request control
// Overview of operation
// - precharge bit 0 gives one precharge state, 1 gives two
// - burst bit 0 forces full access, 1 allows fast page bursts
// - hold-row bit keeps row strobe low between interrupted accesses
// - dual column strobe bit selects 8-bit (1) or 16-bit (0) space
// - shift code 00/01/10 shifts row address by 8/9/10 bits
// - burst row compare uses bits 23 down to shift, plus one if 16-bit
// - refresh wait field adds zero to three waits to refresh cycles
// - external wait input ignored during cas-before-ras refresh
// - control registers reset to zero, kept over manual reset
// - refresh enable 0 means no refresh, timer still usable
// - strobe wait bit adds one wait, row strobe falls later
// - refresh mode selects cas-before-ras (0) or self refresh (1)
// - compare flag sets when counter equals compare value
// - flag clears only by writing 0 after reading it as 1
// - interrupt raised when flag set and interrupt enable is 1
// - interrupt enable held at 0 while refresh is enabled
// - counter clock codes 1..7 give divide by 2 up to 4096
// - code 000 stops the counter, nonzero starts counting
// - match clears counter and starts a refresh when enabled
// - compare register resets to all ones, compared continuously
`timescale 1ns/1ps
module drc_top (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_manual_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [3:0] i_area_is_dram,
   input wire logic [2:0] i_area_sel,
   input wire logic i_access_req,
   input wire logic [23:0] i_access_addr,
   input wire logic [23:0] i_last_addr,
   input wire logic i_seq_break,
   input wire logic i_wait_n,
   input wire logic i_refresh_done,
   output logic o_dram_sel,
   output logic [1:0] o_precharge_states,
   output logic o_burst_ok,
   output logic o_row_hold_low,
   output logic o_byte_space,
   output logic [23:0] o_row_addr,
   output logic o_row_hit,
   output logic [1:0] o_refresh_waits,
   output logic o_ext_wait,
   output logic o_refresh_req,
   output logic o_self_refresh,
   output logic o_strobe_late,
   output logic o_compare_match_irq
);
   import drc_pkg::*;

   typedef struct packed {
      logic [7:0] mtc;
      logic [7:0] rfc;
      logic [7:0] cnt;
      logic [7:0] cmp;
      logic flag_seen;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic dram_sel;
      logic [1:0] pre_states;
      logic burst_ok;
      logic row_hold;
      logic ext_wait;
      logic refresh_req;
      logic self_ref;
      logic irq;
      logic in_refresh;
   } drc_state_s;

   drc_state_s st_q;
   drc_state_s st_d;
   logic tick;
   logic match;
   logic acc_phase;
   logic wr;
   logic rd;
   logic area_dram;
   logic refresh_on;
   logic [2:0] area_idx;

   drc_prescaler #(
      .WIDTH(12)
   ) u_prescaler (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_sel(st_q.rfc[RFC_CLK_SEL_LSB +: 3]),
      .o_tick(tick)
   );

   drc_row_compare u_row (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_addr(i_access_addr),
      .i_last_addr(i_last_addr),
      .i_shift(st_q.mtc[MTC_MUX_SHIFT_LSB +: 2]),
      .i_byte_space(st_q.mtc[MTC_DUAL_CAS_BIT]),
      .o_row(o_row_addr),
      .o_row_hit(o_row_hit)
   );

   always_comb begin
      st_d = st_q;
      acc_phase = i_psel && i_penable && !st_q.ready;
      wr = acc_phase && i_pwrite;
      rd = acc_phase && !i_pwrite;
      area_idx = i_area_sel - 3'h2;
      // only areas 2 to 5 may be dram space
      area_dram = (i_area_sel >= 3'h2) && (i_area_sel <= 3'h5)
         && i_area_is_dram[area_idx[1:0]];
      refresh_on = st_q.rfc[RFC_ENABLE_BIT];
      match = (st_q.cnt == st_q.cmp);

      st_d.ready = acc_phase;
      st_d.err = 1'b0;
      st_d.rdata = '0;

      // refresh counter: clear on match, else count on prescaler tick
      if (match) begin
         st_d.cnt = 8'h00;
      end else if (tick) begin
         st_d.cnt = st_q.cnt + 8'h01;
      end

      if (rd) begin
         case (i_paddr)
            MTC_OFFSET: st_d.rdata = {24'h0, st_q.mtc};
            RFC_OFFSET: begin
               st_d.rdata = {24'h0, st_q.rfc};
               if (st_q.rfc[RFC_FLAG_BIT]) begin
                  st_d.flag_seen = 1'b1;
               end
            end
            CNT_OFFSET: st_d.rdata = {24'h0, st_q.cnt};
            CMP_OFFSET: st_d.rdata = {24'h0, st_q.cmp};
            STS_OFFSET: st_d.rdata = {30'h0, st_q.in_refresh,
               st_q.refresh_req};
            default: st_d.err = 1'b1;
         endcase
      end

      if (wr) begin
         case (i_paddr)
            MTC_OFFSET: st_d.mtc = i_pwdata[7:0];
            RFC_OFFSET: begin
               // software expected to write flag as 1 when refreshing
               st_d.rfc = {i_pwdata[7:5], st_q.rfc[RFC_FLAG_BIT],
                  i_pwdata[3:0]};
               if (!i_pwdata[RFC_FLAG_BIT] && st_q.flag_seen) begin
                  st_d.rfc[RFC_FLAG_BIT] = 1'b0;
                  st_d.flag_seen = 1'b0;
               end
            end
            CNT_OFFSET: begin
               if (!match) begin
                  st_d.cnt = i_pwdata[7:0];
               end
            end
            CMP_OFFSET: st_d.cmp = i_pwdata[7:0];
            STS_OFFSET: st_d.err = 1'b0;
            default: st_d.err = 1'b1;
         endcase
      end

      // hardware set wins over a clearing write in the same cycle
      if (match) begin
         st_d.rfc[RFC_FLAG_BIT] = 1'b1;
      end
      if (st_d.rfc[RFC_ENABLE_BIT]) begin
         st_d.rfc[RFC_IRQ_EN_BIT] = 1'b0;
      end

      st_d.irq = st_q.rfc[RFC_FLAG_BIT] && st_q.rfc[RFC_IRQ_EN_BIT];

      // refresh request held until the bus side reports completion or refresh is disabled
      if (match && refresh_on) begin
         st_d.refresh_req = 1'b1;
      end else if (i_refresh_done || !refresh_on) begin
         st_d.refresh_req = 1'b0;
      end
      st_d.self_ref = refresh_on && st_q.rfc[RFC_MODE_BIT];
      st_d.in_refresh = st_q.refresh_req && !st_q.rfc[RFC_MODE_BIT];

      // dram timing driven only for dram areas
      st_d.dram_sel = i_access_req && area_dram;
      st_d.pre_states = area_dram ?
         (st_q.mtc[MTC_PRECHARGE_BIT] ? 2'h2 : 2'h1) : 2'h0;
      st_d.burst_ok = area_dram && st_q.mtc[MTC_BURST_BIT];
      // row strobe stays low on a break only in hold mode
      st_d.row_hold = area_dram && i_seq_break
         && st_q.mtc[MTC_ROW_HOLD_BIT];
      // wait pin masked from the request edge, not one cycle later
      st_d.ext_wait = ((st_q.refresh_req && !st_q.rfc[RFC_MODE_BIT])
         || st_q.in_refresh) ? 1'b0 : !i_wait_n;

      // manual reset only clears the bus ready flag, every other register untouched
      if (i_manual_rst) begin
         st_d.ready = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_q <= '0;
         st_q.mtc <= MTC_RESET;
         st_q.rfc <= RFC_RESET;
         st_q.cnt <= CNT_RESET;
         st_q.cmp <= CMP_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_prdata = st_q.rdata;
   assign o_pready = st_q.ready;
   assign o_pslverr = st_q.err;
   assign o_dram_sel = st_q.dram_sel;
   assign o_precharge_states = st_q.pre_states;
   assign o_burst_ok = st_q.burst_ok;
   assign o_row_hold_low = st_q.row_hold;
   assign o_byte_space = st_q.mtc[MTC_DUAL_CAS_BIT];
   assign o_refresh_waits = st_q.mtc[MTC_REFRESH_WAIT_LSB +: 2];
   assign o_ext_wait = st_q.ext_wait;
   assign o_refresh_req = st_q.refresh_req;
   assign o_self_refresh = st_q.self_ref;
   assign o_strobe_late = st_q.rfc[RFC_STROBE_WAIT_BIT];
   assign o_compare_match_irq = st_q.irq;

   // refresh timer, flag and interrupt
   a_match_flag: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (st_q.cnt == st_q.cmp) |=> st_q.rfc[RFC_FLAG_BIT] && st_q.cnt == 8'h00)
      else $error("match did not set flag");
   a_irq_gate: assert property (@(posedge i_clk)
      disable iff (i_srst)
      o_compare_match_irq |-> $past(st_q.rfc[RFC_IRQ_EN_BIT]))
      else $error("irq without enable");
   a_irq_off: assert property (@(posedge i_clk)
      disable iff (i_srst)
      !st_q.rfc[RFC_IRQ_EN_BIT] |=> !o_compare_match_irq)
      else $error("irq raised while disabled");
   a_irq_on: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (st_q.rfc[RFC_FLAG_BIT] && st_q.rfc[RFC_IRQ_EN_BIT]) |=>
      o_compare_match_irq)
      else $error("irq missing with flag and enable");
   a_irqen_forced: assert property (@(posedge i_clk)
      disable iff (i_srst)
      st_q.rfc[RFC_ENABLE_BIT] |-> !st_q.rfc[RFC_IRQ_EN_BIT])
      else $error("irq enable set while refreshing");
   a_flag_noread: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (st_q.rfc[RFC_FLAG_BIT] && !st_q.flag_seen) |=> st_q.rfc[RFC_FLAG_BIT])
      else $error("flag cleared unread");
   a_flag_clear: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (wr && i_paddr == RFC_OFFSET && !i_pwdata[RFC_FLAG_BIT]
      && st_q.flag_seen && !match) |=> !st_q.rfc[RFC_FLAG_BIT])
      else $error("armed flag not cleared by write");
   a_flag_sticky: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (st_q.rfc[RFC_FLAG_BIT] && !(wr && i_paddr == RFC_OFFSET)) |=>
      st_q.rfc[RFC_FLAG_BIT])
      else $error("flag cleared without write");
   a_cnt_hold: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (!tick && !match && !(wr && i_paddr == CNT_OFFSET)) |=>
      $stable(st_q.cnt))
      else $error("counter moved without tick");
   a_cnt_step: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (tick && !match && !(wr && i_paddr == CNT_OFFSET)) |=>
      (st_q.cnt == $past(st_q.cnt) + 8'h01))
      else $error("counter did not step on tick");
   a_reset_vals: assert property (@(posedge i_clk)
      $fell(i_srst) |-> (st_q.mtc == MTC_RESET && st_q.rfc == RFC_RESET
      && st_q.cnt == CNT_RESET && st_q.cmp == CMP_RESET))
      else $error("register reset value wrong");

   // refresh request and wait masking
   a_refresh_start: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (st_q.cnt == st_q.cmp && st_q.rfc[RFC_ENABLE_BIT]) |=> o_refresh_req)
      else $error("no refresh on match");
   a_refresh_hold: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (o_refresh_req && !i_refresh_done && st_q.rfc[RFC_ENABLE_BIT]) |=>
      o_refresh_req)
      else $error("refresh request dropped early");
   a_no_refresh: assert property (@(posedge i_clk)
      disable iff (i_srst)
      !$past(st_q.rfc[RFC_ENABLE_BIT]) |-> !o_refresh_req)
      else $error("refresh while disabled");
   a_wait_ignored: assert property (@(posedge i_clk)
      disable iff (i_srst)
      st_q.in_refresh |=> !o_ext_wait)
      else $error("wait passed in refresh");
   a_wait_mask: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (st_q.refresh_req && !st_q.rfc[RFC_MODE_BIT]) |=> !o_ext_wait)
      else $error("wait not masked at refresh start");
   a_wait_pass: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (!st_q.refresh_req && !st_q.in_refresh) |=>
      (o_ext_wait == !$past(i_wait_n)))
      else $error("wait pin not passed outside refresh");
   a_self_mode: assert property (@(posedge i_clk)
      disable iff (i_srst)
      o_self_refresh |-> $past(st_q.rfc[RFC_ENABLE_BIT]))
      else $error("self refresh while off");
   a_self_on: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (st_q.rfc[RFC_ENABLE_BIT] && st_q.rfc[RFC_MODE_BIT]) |=> o_self_refresh)
      else $error("self refresh not selected");
   a_cbr_only: assert property (@(posedge i_clk)
      disable iff (i_srst)
      (o_refresh_req && !st_q.rfc[RFC_MODE_BIT]) |=> st_q.in_refresh)
      else $error("cas-before-ras refresh not entered");

   // access timing for dram areas
   a_precharge: assert property (@(posedge i_clk)
      disable iff (i_srst)
      o_dram_sel |-> o_precharge_states ==
      ($past(st_q.mtc[MTC_PRECHARGE_BIT]) ? 2'h2 : 2'h1))
      else $error("precharge length wrong");
   a_burst_gate: assert property (@(posedge i_clk)
      disable iff (i_srst)
      o_burst_ok |-> $past(st_q.mtc[MTC_BURST_BIT]))
      else $error("burst without enable");
   a_burst_off: assert property (@(posedge i_clk)
      disable iff (i_srst)
      !st_q.mtc[MTC_BURST_BIT] |=> !o_burst_ok)
      else $error("burst while disabled");
   a_row_hold: assert property (@(posedge i_clk)
      disable iff (i_srst)
      o_row_hold_low |->
      ($past(st_q.mtc[MTC_ROW_HOLD_BIT]) && $past(i_seq_break)))
      else $error("row strobe held outside hold mode");
   a_normal_area: assert property (@(posedge i_clk)
      disable iff (i_srst)
      !area_dram |=>
      (!o_dram_sel && !o_burst_ok && o_precharge_states == 2'h0))
      else $error("dram timing on normal area");
endmodule

// >>> test/drc_dram_model.sv
// far-side dram model: answers refresh requests, drives the wait pin
`timescale 1ns/1ps
module drc_dram_model (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_refresh_req,
   input wire logic [3:0] i_delay,
   input wire logic i_wait_low,
   output logic o_refresh_done,
   output logic o_wait_n
);
   logic [3:0] cnt_q;
   // refresh lasts i_delay plus one cycles, a slow answer needs a large delay
   always_ff @(posedge i_clk) begin
      if (i_srst || !i_refresh_req || o_refresh_done) begin
         cnt_q <= 4'h0;
         o_refresh_done <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
         o_refresh_done <= (cnt_q == i_delay);
      end
   end
   // wait held low through refresh: it must be ignored there
   assign o_wait_n = !(i_refresh_req || i_wait_low);
endmodule

// >>> test/testbench.sv
// self-checking bench for dram refresh control
`timescale 1ns/1ps
module testbench;
   import drc_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic mrst = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] is_dram = 4'h1;
   logic [2:0] area = 3'h2;
   logic req = 1'b0;
   logic brk = 1'b1;
   logic wait_low = 1'b0;
   logic [23:0] addr = 24'hc3a5f0;
   logic [23:0] last = 24'h0;
   logic [3:0] dly = 4'h2;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, wait_n, rdone, dsel, bok, hold, bsp, hit;
   logic ewait, rreq, selfr, late, irq;
   logic [1:0] pch, rw;
   logic [23:0] row;
   int n_fail = 0;
   int total_checks = 0;
   int n;
   int w;

   always #4 clk = ~clk;

   drc_top uut (
      .i_clk(clk), .i_srst(srst), .i_manual_rst(mrst),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr),
      .i_area_is_dram(is_dram), .i_area_sel(area),
      .i_access_req(req), .i_access_addr(addr), .i_last_addr(last),
      .i_seq_break(brk), .i_wait_n(wait_n), .i_refresh_done(rdone),
      .o_dram_sel(dsel), .o_precharge_states(pch), .o_burst_ok(bok),
      .o_row_hold_low(hold), .o_byte_space(bsp), .o_row_addr(row),
      .o_row_hit(hit), .o_refresh_waits(rw), .o_ext_wait(ewait),
      .o_refresh_req(rreq), .o_self_refresh(selfr),
      .o_strobe_late(late), .o_compare_match_irq(irq)
   );

   drc_dram_model dram (
      .i_clk(clk), .i_srst(srst), .i_refresh_req(rreq), .i_delay(dly),
      .i_wait_low(wait_low), .o_refresh_done(rdone), .o_wait_n(wait_n)
   );

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) n_fail++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input string nm, input logic [11:0] a,
                      input logic [31:0] exp);
      apb(1'b0, a, 8'h00);
      chk(nm, exp, rd);
   endtask

   task automatic stop_test();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // whole run needs about 30000 cycles, the slow dividers dominate
   initial begin
      cyc(60000);
      n_fail++;
      stop_test();
   end

   initial begin
      cyc(16);
      srst <= 1'b0;
      rdc("mtc", MTC_OFFSET, 32'h0);
      rdc("rfc", RFC_OFFSET, 32'h0);
      rdc("cnt", CNT_OFFSET, 32'h0);
      rdc("cmp", CMP_OFFSET, 32'hff);
      apb(1'b0, 12'h020, 8'h00);
      chk("slverr", 1, err);
      wr(MTC_OFFSET, 8'hf0);
      req <= 1'b1;
      cyc(2);
      chk("dsel", 1, dsel);
      chk("pch", 2, pch);
      chk("burst", 1, bok);
      chk("hold", 1, hold);
      chk("byte", 1, bsp);
      mrst <= 1'b1;
      cyc(2);
      mrst <= 1'b0;
      rdc("mtc kept", MTC_OFFSET, 32'hf0);
      wr(MTC_OFFSET, 8'h03);
      cyc(2);
      chk("pch", 1, pch);
      chk("burst", 0, bok);
      chk("hold", 0, hold);
      chk("byte", 0, bsp);
      chk("waits", 3, rw);
      area <= 3'h3;
      cyc(2);
      chk("normal pch", 0, pch);
      area <= 3'h2;
      // lowest differing bit sits at the 8-bit compare edge
      for (int c = 0; c < 3; c++) begin
         for (int b = 0; b < 2; b++) begin
            wr(MTC_OFFSET, {3'b000, b[0], c[1:0], 2'b00});
            last <= addr ^ (24'h1 << (8 + c));
            cyc(2);
            chk("row", addr >> (8 + c), row);
            chk("hit", {31'h0, ~b[0]}, hit);
         end
      end
      wr(CMP_OFFSET, 8'h03);
      wr(RFC_OFFSET, 8'h01);
      cyc(20);
      wr(RFC_OFFSET, 8'h00);
      cyc(2);
      chk("irq off", 0, irq);
      wr(RFC_OFFSET, 8'h08);
      cyc(2);
      chk("irq on", 1, irq);
      rdc("flag", RFC_OFFSET, 32'h18);
      wr(RFC_OFFSET, 8'h00);
      rdc("flag clr", RFC_OFFSET, 32'h0);
      wr(CNT_OFFSET, 8'h05);
      cyc(10);
      rdc("stopped", CNT_OFFSET, 32'h05);
      wr(CMP_OFFSET, 8'hff);
      // every divider code, long enough for a few ticks of the slowest
      for (int k = 1; k < 8; k++) begin
         n = (k == 7) ? 4096 : 2 << (2 * (k - 1));
         w = (n < 128) ? 256 : 4 * n;
         wr(CNT_OFFSET, 8'h00);
         wr(RFC_OFFSET, k[7:0]);
         cyc(w);
         wr(RFC_OFFSET, 8'h00);
         apb(1'b0, CNT_OFFSET, 8'h00);
         chk("rate", 1, rd >= w / n && rd <= (w + 8) / n + 1);
      end
      wr(CMP_OFFSET, 8'h04);
      wr(CNT_OFFSET, 8'h00);
      wr(RFC_OFFSET, 8'hd9);
      cyc(2);
      chk("late", 1, late);
      chk("self", 0, selfr);
      apb(1'b0, RFC_OFFSET, 8'h00);
      chk("irq en", 0, rd[3]);
      n = 0;
      while (rreq !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk("refresh req", 1, rreq);
      cyc(1);
      chk("wait ignored", 0, ewait);
      n = 0;
      while (rreq === 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk("refresh done", 0, rreq);
      wr(RFC_OFFSET, 8'h90);
      cyc(10);
      wait_low <= 1'b1;
      cyc(2);
      chk("wait used", 1, ewait);
      wait_low <= 1'b0;
      wr(RFC_OFFSET, 8'hb0);
      cyc(2);
      chk("self", 1, selfr);
      wr(RFC_OFFSET, 8'h01);
      cyc(40);
      chk("no refresh", 0, rreq);
      rdc("status", STS_OFFSET, 32'h0);
      apb(1'b0, RFC_OFFSET, 8'h00);
      chk("timer flag", 1, rd[4]);
      stop_test();
   end
endmodule
